// >>> core/raf_core.sv
// Reading averaging filter plus measurement configuration settings.
// Assumes readings arrive as one-cycle strobes no faster than every 40 cycles.
// What this block does
// R1: Depth setting from 2 to 100, that many readings kept in storage.
// R2: Moving mode keeps readings in first-in first-out order.
// R3: After power-up or reconfiguration the first reading loads before any average.
// R4: Moving mode: new reading replaces oldest, fresh average each reading.
// R5: Repeat mode: wait for full stack, output average, then empty it.
// R6: Repeat mode gives exactly one output per depth readings.
// R7: Averaging bypassed for diode, continuity, frequency and period.
// R8: Power-up: averaging on, moving mode, depth 10.
// R9: Filter key toggles averaging; indicator follows the enable one cycle later.
// R10: Three AC bandwidths 3, 20, 200 Hz each selecting its filter.
// R11: Power-up selects medium 20 Hz bandwidth.
// R12: Bandwidth choice volatile, reverts to default on power removal.
// R13: Six resolutions: fast and slow of 4.5, 5.5, 6.5 digits.
// R14: Separate resolution per function, applied while that function is selected.
// R15: Resolution returns to slow 5.5 after power loss or remote reset.
// R16: AC functions measure at 6.5 digits; lower choice only blanks digits.
// R17: Digits key steps 4.5 slow, 5.5 slow, 6.5 fast cyclically.
// R18: Frequency and period limited to slow 4.5, 5.5, 6.5.
// R19: Default 10M; high resistance only on 100mV, 1V, 10V ranges.
// R20: Auto on selects above 10G on three lowest ranges; off holds 10M.
// R21: Auto zero and integration time follow the resolution table.
// R22: Average is sum over readings held, wide accumulation avoids overflow.
module raf_core
  import raf_pkg::*;
(
  // Clock and reset
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_resetn,
  // Register port
  input  wire logic [raf_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [31:0]                  i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output logic      [31:0]                  o_rdata,
  // Front panel keys and remote reset, same clock domain
  input  wire logic                         i_filter_key,
  input  wire logic                         i_digits_key,
  input  wire logic                         i_remote_reset,
  // Converter readings
  input  wire logic [raf_pkg::READING_W-1:0] i_reading,
  input  wire logic                         i_reading_valid,
  // Filtered readings
  output logic      [raf_pkg::READING_W-1:0] o_filtered,
  output logic                              o_filtered_valid,
  // Settings outputs
  output logic                              o_averaging_on_indicator,
  output logic      [1:0]                   o_ac_filter_sel,
  output logic      [2:0]                   o_active_res,
  output logic      [2:0]                   o_display_digits,
  output logic                              o_high_input_r,
  output logic                              o_auto_zero,
  output logic      [1:0]                   o_plc_sel
);
  import raf_pkg::*;

  // Reset release through two flip-flops
  logic rst_sync1_q, rst_n_q;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync1_q <= 1'b0;
      rst_n_q     <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_n_q     <= rst_sync1_q;
    end
  end

  // Register strobes decoded by address
  wire wr_ctrl  = i_wr && (i_addr == ADDR_AVERAGING_ON_INDICATOR_CTRL);
  wire wr_bw    = i_wr && (i_addr == ADDR_AC_BW);
  wire wr_res   = i_wr && (i_addr == ADDR_RES_SEL);
  wire wr_inr   = i_wr && (i_addr == ADDR_INPUT_R);
  wire wr_func  = i_wr && (i_addr == ADDR_FUNC);

  // Settings state
  logic               avg_en_q, mode_q, auto_r_q;
  logic [DEPTH_W-1:0] depth_q;
  logic [1:0]         bw_q;
  logic [3:0]         func_q;
  logic [2:0]         range_q;
  logic [2:0]         res_q [NFUNC];

  // R1: Depth clamped into the legal 2..100 span
  wire [DEPTH_W-1:0] wdepth  = i_wdata[CTRL_DEPTH_LSB +: DEPTH_W];
  wire [DEPTH_W-1:0] depth_d = (wdepth < DEPTH_W'(DEPTH_MIN)) ? DEPTH_W'(DEPTH_MIN) :
                               (wdepth > DEPTH_W'(DEPTH_MAX)) ? DEPTH_W'(DEPTH_MAX) : wdepth;
  // R10: Only the three bandwidth codes are accepted
  wire bw_ok = (i_wdata[1:0] == BW_SLOW_3HZ) || (i_wdata[1:0] == BW_MED_20HZ) ||
               (i_wdata[1:0] == BW_FAST_200HZ);

  // R8, R9, R11, R12, R19, R20: Power-up defaults, key toggle, setting writes
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      avg_en_q <= EN_RESET;
      mode_q   <= MODE_MOVING;
      depth_q  <= DEPTH_RESET;
      bw_q     <= BW_MED_20HZ;
      auto_r_q <= 1'b0;
      range_q  <= 3'h0;
      func_q   <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        avg_en_q <= i_wdata[CTRL_EN_BIT];
        mode_q   <= i_wdata[CTRL_MODE_BIT];
        depth_q  <= depth_d;
      end else if (i_filter_key) begin
        avg_en_q <= ~avg_en_q;
      end
      if (wr_bw && bw_ok) bw_q <= i_wdata[1:0];
      if (wr_inr) begin
        auto_r_q <= i_wdata[0];
        range_q  <= i_wdata[6:4];
      end
      if (wr_func && (i_wdata[3:0] < 4'(NFUNC))) func_q <= i_wdata[3:0];
    end
  end

  // R17: Digits key sequence, R18: slow-only choices for frequency and period
  wire freq_like = (func_q == FN_FREQ) || (func_q == FN_PERIOD);
  wire ac_func   = (func_q == FN_ACV) || (func_q == FN_ACI);
  logic [2:0] key_next;
  always_comb begin
    key_next = RES_S45;
    if (res_q[func_q] == RES_S45) key_next = RES_S55;
    else if (res_q[func_q] == RES_S55) key_next = freq_like ? RES_S65 : RES_F65;
  end
  // R13: Six legal codes
  wire [2:0] wres     = i_wdata[2:0];
  wire       wres_ok  = (wres <= RES_S65) && (!freq_like || wres[0]);

  // R14, R15: One resolution per function, slow 5.5 on reset
  for (genvar f = 0; f < NFUNC; f++) begin : g_res
    always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        res_q[f] <= RES_S55;
      end else if (i_remote_reset) begin
        res_q[f] <= RES_S55;
      end else if (func_q == 4'(f)) begin
        if (wr_res && wres_ok) res_q[f] <= wres;
        else if (i_digits_key) res_q[f] <= key_next;
      end
    end
  end

  // R7: Functions without averaging
  wire bypass = (func_q == FN_DIODE) || (func_q == FN_CONT) || freq_like;
  wire averaging_on_indicator_on = avg_en_q && !bypass;

  // Reading store and running sum
  logic [READING_W-1:0] stack_q [DEPTH_MAX];
  logic [DEPTH_W-1:0]   wptr_q, count_q;
  logic [ACC_W-1:0]     sum_q;
  logic                 reconf_q;
  // Until full, moving mode averages only what has arrived
  wire full        = (count_q == depth_q);
  wire [ACC_W-1:0] oldest = ACC_W'(stack_q[wptr_q]);
  wire [ACC_W-1:0] newv   = ACC_W'(i_reading);
  // R4: Oldest value leaves the sum when the new one enters
  wire [ACC_W-1:0] sum_next = (full && mode_q == MODE_MOVING) ? sum_q - oldest + newv
                                                               : sum_q + newv;
  wire [DEPTH_W-1:0] wptr_inc = (wptr_q + 7'h01 == depth_q) ? 7'h00 : wptr_q + 7'h01;
  wire [DEPTH_W-1:0] cnt_inc  = full ? count_q : count_q + 7'h01;
  wire take = i_reading_valid && averaging_on_indicator_on;
  raf_state_type st_q;
  wire start_div = take && (mode_q == MODE_MOVING || cnt_inc == depth_q);

  // R3: Filter control writes, the filter key and function writes restart the fill from an empty stack
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) reconf_q <= 1'b0;
    else          reconf_q <= wr_ctrl || i_filter_key || wr_func;
  end

  // R2: Stack written in circular first-in first-out order
  always_ff @(posedge i_ref_clk) begin
    if (take) stack_q[wptr_q] <= i_reading;
  end

  // R5, R6: Repeat mode flushes after each full group
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wptr_q  <= 7'h00;
      count_q <= 7'h00;
      sum_q   <= '0;
    end else if (reconf_q || (st_q == ST_DONE && mode_q == MODE_REPEAT)) begin
      // Synchronous flush, so the reset branch stays constant-only
      wptr_q  <= 7'h00;
      count_q <= 7'h00;
      sum_q   <= '0;
    end else if (take) begin
      wptr_q  <= wptr_inc;
      count_q <= cnt_inc;
      sum_q   <= sum_next;
    end
  end

  // R22: Restoring divider, sum over readings held, one bit a cycle
  logic [ACC_W-1:0] quo_q, rem_q;
  logic [5:0]       bit_q;
  logic [DEPTH_W-1:0] div_by_q;
  wire [ACC_W-1:0] rem_sh = {rem_q[ACC_W-2:0], quo_q[ACC_W-1]};
  wire             ge     = rem_sh >= ACC_W'(div_by_q);
  // 32 steps per average; readings must be spaced wider than that
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ST_IDLE;
      quo_q <= '0;
      rem_q <= '0;
      bit_q <= 6'h00;
      div_by_q <= DEPTH_RESET;
    end else begin
      case (st_q)
        ST_IDLE: if (start_div) begin
          st_q <= ST_DIVIDE;
          quo_q <= sum_next;
          rem_q <= '0;
          bit_q <= 6'h00;
          div_by_q <= cnt_inc;
        end
        ST_DIVIDE: begin
          rem_q <= ge ? rem_sh - ACC_W'(div_by_q) : rem_sh;
          quo_q <= {quo_q[ACC_W-2:0], ge};
          bit_q <= bit_q + 6'h01;
          if (bit_q == 6'(ACC_W - 1)) st_q <= ST_DONE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Output: average when filtering, raw reading when bypassed
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_filtered       <= '0;
      o_filtered_valid <= 1'b0;
    end else if (st_q == ST_DONE) begin
      o_filtered       <= quo_q[READING_W-1:0];
      o_filtered_valid <= 1'b1;
    end else if (i_reading_valid && !averaging_on_indicator_on) begin
      o_filtered       <= i_reading;
      o_filtered_valid <= 1'b1;
    end else begin
      o_filtered_valid <= 1'b0;
    end
  end

  // R16, R19, R20, R21: Derived measurement settings
  wire [2:0] act_res  = ac_func ? RES_F65 : res_q[func_q];
  wire [2:0] disp_res = res_q[func_q];
  wire       highr    = auto_r_q && (func_q == FN_DCV) && (range_q <= RANGE_HIGHR_MAX);
  wire       az       = !(act_res == RES_F45 || act_res == RES_F55);
  logic [1:0] plc;
  always_comb begin
    case (act_res)
      RES_F45:          plc = PLC_0P02;
      RES_S45, RES_F55: plc = PLC_0P1;
      RES_S65:          plc = PLC_10;
      default:          plc = PLC_1;
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_averaging_on_indicator <= EN_RESET;
      o_ac_filter_sel  <= BW_MED_20HZ;
      o_active_res     <= RES_S55;
      o_display_digits <= RES_S55;
      o_high_input_r   <= 1'b0;
      o_auto_zero      <= 1'b1;
      o_plc_sel        <= PLC_1;
    end else begin
      o_averaging_on_indicator <= avg_en_q; // Follows enable one cycle later
      o_ac_filter_sel  <= bw_q;
      o_active_res     <= act_res;
      o_display_digits <= disp_res;
      o_high_input_r   <= highr;
      o_auto_zero      <= az;
      o_plc_sel        <= plc;
    end
  end

  // Read data mux
  wire [31:0] rd_mux =
    (i_addr == ADDR_AVERAGING_ON_INDICATOR_CTRL) ? {17'h0, depth_q, 6'h0, mode_q, avg_en_q} :
    (i_addr == ADDR_AVERAGING_ON_INDICATOR_STAT) ? {23'h0, count_q, 2'(st_q)} :
    (i_addr == ADDR_AC_BW)     ? {30'h0, bw_q} :
    (i_addr == ADDR_RES_SEL)   ? {29'h0, res_q[func_q]} :
    (i_addr == ADDR_INPUT_R)   ? {25'h0, range_q, 3'h0, auto_r_q} :
    (i_addr == ADDR_FUNC)      ? {28'h0, func_q} :
    (i_addr == ADDR_TIMING)    ? {28'h0, az, 1'b0, plc} : 32'h0;
  always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) o_rdata <= 32'h0;
    else          o_rdata <= i_rd ? rd_mux : 32'h0;
  end

  // Checks
  a_depth_range: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R1
    depth_q >= DEPTH_W'(DEPTH_MIN) && depth_q <= DEPTH_W'(DEPTH_MAX)) else $error("depth out");
  a_indicator_follows: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R9
    o_averaging_on_indicator == $past(avg_en_q)) else $error("indicator wrong");
  a_bypass_pass: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R7
    i_reading_valid && bypass && st_q == ST_IDLE |=> o_filtered_valid && o_filtered == $past(i_reading))
    else $error("bypass lost");
  a_repeat_flush: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R5
    st_q == ST_DONE && mode_q == MODE_REPEAT && !reconf_q |=> count_q == 7'h00)
    else $error("no flush");
  a_count_bound: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R6
    count_q <= depth_q || reconf_q) else $error("count over");
  a_div_time: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R4
    st_q == ST_IDLE && start_div |=> ##[31:32] st_q == ST_DONE) else $error("late average");
  a_highr_gate: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R19
    o_high_input_r |-> $past(func_q) == FN_DCV && $past(range_q) <= RANGE_HIGHR_MAX)
    else $error("high R misused");
  a_ac_full_res: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R16
    ac_func |=> o_active_res == RES_F65) else $error("AC res not 6.5");
  a_remote_res: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R15
    i_remote_reset |=> res_q[func_q] == RES_S55) else $error("res not restored");

  // R3: Reconfiguration empties stack
  a_reconf_empty: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R3
    reconf_q |=> count_q == 7'h00 && wptr_q == 7'h00) else $error("stack not emptied");

  // R4: Moving output per reading
  a_moving_every: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R4
    take && mode_q == MODE_MOVING && st_q == ST_IDLE |-> ##34 o_filtered_valid)
    else $error("moving output missing");

  // R6: No output before group full
  a_repeat_hold: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R6
    take && mode_q == MODE_REPEAT && st_q == ST_IDLE && cnt_inc != depth_q |=> st_q == ST_IDLE)
    else $error("early repeat output");

  // R9: Filter key toggles enable
  a_key_toggle: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R9
    i_filter_key && !wr_ctrl |=> avg_en_q != $past(avg_en_q)) else $error("key ignored");

  // R10: Only three bandwidths
  a_bw_legal: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R10
    o_ac_filter_sel != 2'h3) else $error("bad bandwidth code");

  // R13: Resolution codes legal
  a_res_legal: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R13
    o_display_digits <= RES_S65 && o_active_res <= RES_S65) else $error("bad resolution code");

  // R17: Digits key step
  a_digits_step: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R17
    i_digits_key && !i_remote_reset && !i_wr && !freq_like && res_q[func_q] == RES_S55
    |=> res_q[func_q] == RES_F65) else $error("digits step wrong");

  // R18: Frequency stays slow
  a_freq_slow: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R18
    freq_like |-> res_q[func_q][0]) else $error("fast res in freq");

  // R20: Auto off holds 10M
  a_auto_off: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R20
    !auto_r_q |=> !o_high_input_r) else $error("high R while auto off");

  // R21: Shortest time, no zeroing
  a_fast_no_zero: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q) // R21
    o_plc_sel == PLC_0P02 |-> !o_auto_zero) else $error("zeroing at 0.02 PLC");

  // Main scenarios reached
  c_moving_out: cover property (@(posedge i_ref_clk) mode_q == MODE_MOVING && o_filtered_valid);
  c_repeat_out: cover property (@(posedge i_ref_clk) mode_q == MODE_REPEAT && st_q == ST_DONE);
  c_key_toggle: cover property (@(posedge i_ref_clk) i_filter_key ##1 !avg_en_q);
  c_bypass_out: cover property (@(posedge i_ref_clk) bypass && o_filtered_valid);
  c_digits_wrap: cover property (@(posedge i_ref_clk) i_digits_key && res_q[func_q] == RES_F65);
endmodule

// >>> core/raf_pkg.sv
// Package for the reading average filter and measurement configuration block.
// Assumes one 50 MHz clock; all counts and codes used by the core live here.
package raf_pkg;
  // Reading width and accumulator width (100 x 24-bit fits in 31 bits)
  localparam int unsigned READING_W   = 24;
  localparam int unsigned ACC_W       = 32;
  localparam int unsigned DEPTH_MIN   = 2;
  localparam int unsigned DEPTH_MAX   = 100;
  localparam int unsigned DEPTH_W     = 7;
  localparam logic [6:0]  DEPTH_RESET = 7'h0a;
  // Register map, word addresses on the plain register port
  localparam int unsigned ADDR_W         = 4;
  localparam logic [3:0]  ADDR_AVERAGING_ON_INDICATOR_CTRL = 4'h0;
  localparam logic [3:0]  ADDR_AVERAGING_ON_INDICATOR_STAT = 4'h1;
  localparam logic [3:0]  ADDR_AC_BW     = 4'h2;
  localparam logic [3:0]  ADDR_RES_SEL   = 4'h3;
  localparam logic [3:0]  ADDR_INPUT_R   = 4'h4;
  localparam logic [3:0]  ADDR_FUNC      = 4'h5;
  localparam logic [3:0]  ADDR_TIMING    = 4'h6;
  // Filter control fields
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_MODE_BIT  = 1;
  localparam int unsigned CTRL_DEPTH_LSB = 8;
  localparam logic        EN_RESET       = 1'b1;
  localparam logic        MODE_MOVING    = 1'b0;
  localparam logic        MODE_REPEAT    = 1'b1;
  // AC bandwidth codes: lower edge 3 Hz, 20 Hz, 200 Hz
  localparam logic [1:0]  BW_SLOW_3HZ    = 2'h0;
  localparam logic [1:0]  BW_MED_20HZ    = 2'h1;
  localparam logic [1:0]  BW_FAST_200HZ  = 2'h2;
  // Resolution codes: {digits index, slow}
  localparam logic [2:0]  RES_F45 = 3'h0;
  localparam logic [2:0]  RES_S45 = 3'h1;
  localparam logic [2:0]  RES_F55 = 3'h2;
  localparam logic [2:0]  RES_S55 = 3'h3;
  localparam logic [2:0]  RES_F65 = 3'h4;
  localparam logic [2:0]  RES_S65 = 3'h5;
  // Integration time codes in line cycles: 0.02, 0.1, 1, 10
  localparam logic [1:0]  PLC_0P02 = 2'h0;
  localparam logic [1:0]  PLC_0P1  = 2'h1;
  localparam logic [1:0]  PLC_1    = 2'h2;
  localparam logic [1:0]  PLC_10   = 2'h3;
  // Measurement functions
  localparam int unsigned NFUNC = 10;
  typedef enum logic [3:0] {
    FN_DCV, FN_ACV, FN_DCI, FN_ACI, FN_RES2, FN_RES4,
    FN_FREQ, FN_PERIOD, FN_DIODE, FN_CONT
  } raf_func_type;
  // DC voltage ranges: the three lowest allow the high input resistance
  localparam logic [2:0]  RANGE_HIGHR_MAX = 3'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_DIVIDE, ST_DONE} raf_state_type;
endpackage

// >>> bench/raf_adc_model.sv
// Converter model feeding readings into the averaging filter.
// Assumes the bench spaces start pulses at least 40 clock cycles apart.
module raf_adc_model
  import raf_pkg::*;
(
  // Clock and reset
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_resetn,
  // Bench request
  input  wire logic                          i_start,
  input  wire logic [raf_pkg::READING_W-1:0] i_value,
  // Reading strobe toward the filter
  output logic      [raf_pkg::READING_W-1:0] o_reading,
  output logic                               o_reading_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle strobe; data flips each idle cycle so stale values never look valid
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reading       <= '0;
      o_reading_valid <= 1'b0;
    end else begin
      o_reading_valid <= i_start;
      o_reading       <= i_start ? i_value : ~o_reading;
    end
  end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the averaging filter and settings block.
// Assumes the converter model in its own file and the package constants.
module testbench
  import raf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_ref_clk, i_resetn, i_wr, i_rd, st;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic        i_filter_key, i_digits_key, i_remote_reset, rv, o_filtered_valid;
  logic [23:0] rdg, val, o_filtered;
  logic        o_averaging_on_indicator, o_high_input_r, o_auto_zero;
  logic [1:0]  o_ac_filter_sel, o_plc_sel;
  logic [2:0]  o_active_res, o_display_digits;
  int          miscompares, samples_checked;
  // Auto zero and integration code per resolution code
  localparam logic [5:0] AZ  = 6'b111010;
  localparam logic [1:0] PLC [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  raf_adc_model adc (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_start(st),
    .i_value(val), .o_reading(rdg), .o_reading_valid(rv));
  raf_core uut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_filter_key(i_filter_key), .i_digits_key(i_digits_key),
    .i_remote_reset(i_remote_reset), .i_reading(rdg), .i_reading_valid(rv),
    .o_filtered(o_filtered), .o_filtered_valid(o_filtered_valid),
    .o_averaging_on_indicator(o_averaging_on_indicator),
    .o_ac_filter_sel(o_ac_filter_sel), .o_active_res(o_active_res),
    .o_display_digits(o_display_digits), .o_high_input_r(o_high_input_r),
    .o_auto_zero(o_auto_zero), .o_plc_sel(o_plc_sel));
  // Free-running 50 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register write; outputs settle one edge after the strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    tick(2);
  endtask
  // Read data only stands in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask
  task automatic press(input int k);
    @(posedge i_ref_clk);
    i_filter_key <= (k == 0); i_digits_key <= (k == 1); i_remote_reset <= (k == 2);
    @(posedge i_ref_clk);
    {i_filter_key, i_digits_key, i_remote_reset} <= 3'h0;
    tick(3);
  endtask
  // One reading, then count outputs over a window wider than the divide
  task automatic feed(input logic [23:0] v, input int n, input logic [23:0] exp);
    int          seen;
    logic [23:0] last;
    seen = 0;
    last = '0;
    @(posedge i_ref_clk);
    st <= 1'b1; val <= v;
    @(posedge i_ref_clk);
    st <= 1'b0;
    repeat (44) begin
      tick(1);
      if (o_filtered_valid === 1'b1) begin
        seen++;
        last = o_filtered;
      end
    end
    chk(32'(seen), 32'(n));
    if (n > 0) chk(32'(last), 32'(exp));
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  initial begin
    #400000;
    miscompares++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    {i_resetn, i_wr, i_rd, st, i_filter_key, i_digits_key, i_remote_reset} = 7'h0;
    i_addr = '0; i_wdata = '0; val = '0;
    miscompares = 0; samples_checked = 0;
    tick(12);
    i_resetn <= 1'b1;
    tick(5);
    chk(32'(o_averaging_on_indicator), 32'h1);
    chk(32'(o_ac_filter_sel), 32'(BW_MED_20HZ));
    chk(32'(o_display_digits), 32'(RES_S55));
    chk(32'(o_high_input_r), 32'h0);
    chk(32'({o_auto_zero, o_plc_sel}), 32'h6);
    rd(ADDR_AVERAGING_ON_INDICATOR_CTRL, 32'h00000a01);
    rd(4'hf, 32'h0);
    $display("test defaults done");
    wr(ADDR_AVERAGING_ON_INDICATOR_CTRL, 32'h6501);
    rd(ADDR_AVERAGING_ON_INDICATOR_CTRL, 32'h00006401);
    wr(ADDR_AVERAGING_ON_INDICATOR_CTRL, 32'h0101);
    rd(ADDR_AVERAGING_ON_INDICATOR_CTRL, 32'h00000201);
    feed(24'd10, 1, 24'd10);
    feed(24'd20, 1, 24'd15);
    feed(24'd30, 1, 24'd25);
    feed(24'hffffff, 1, 24'h80000e);
    wr(ADDR_AVERAGING_ON_INDICATOR_CTRL, 32'h6401);
    for (int i = 0; i < 100; i++) feed(24'hffffff, 1, 24'hffffff);
    feed(24'h0, 1, 24'((64'd99 * 64'hffffff) / 64'd100));
    $display("test moving done");
    wr(ADDR_AVERAGING_ON_INDICATOR_CTRL, 32'h0303);
    feed(24'd3, 0, 24'd0);
    feed(24'd6, 0, 24'd0);
    feed(24'd9, 1, 24'd6);
    feed(24'd1, 0, 24'd0);
    rd(ADDR_AVERAGING_ON_INDICATOR_STAT, 32'h00000004);
    feed(24'd2, 0, 24'd0);
    feed(24'd6, 1, 24'd3);
    $display("test repeat done");
    press(0);
    chk(32'(o_averaging_on_indicator), 32'h0);
    rd(ADDR_AVERAGING_ON_INDICATOR_CTRL, 32'h00000302);
    feed(24'd7, 1, 24'd7);
    press(0);
    chk(32'(o_averaging_on_indicator), 32'h1);
    wr(ADDR_AVERAGING_ON_INDICATOR_CTRL, 32'h0a01);
    for (int f = 6; f < 10; f++) begin
      wr(ADDR_FUNC, 32'(f));
      feed(24'h100 + 24'(f), 1, 24'h100 + 24'(f));
    end
    wr(ADDR_FUNC, 32'h0);
    feed(24'd40, 1, 24'd40);
    feed(24'd20, 1, 24'd30);
    $display("test filter key and bypass done");
    for (int b = 0; b < 3; b++) begin
      wr(ADDR_AC_BW, 32'(b));
      chk(32'(o_ac_filter_sel), 32'(b));
      rd(ADDR_AC_BW, 32'(b));
    end
    wr(ADDR_AC_BW, 32'h3);
    chk(32'(o_ac_filter_sel), 32'(BW_FAST_200HZ));
    $display("test bandwidth done");
    for (int r = 0; r < 6; r++) begin
      wr(ADDR_RES_SEL, 32'(r));
      chk(32'(o_display_digits), 32'(r));
      chk(32'({o_auto_zero, o_plc_sel}), 32'({AZ[r], PLC[r]}));
      rd(ADDR_TIMING, 32'({AZ[r], 1'b0, PLC[r]}));
    end
    wr(ADDR_RES_SEL, 32'(RES_S55));
    press(1);
    chk(32'(o_display_digits), 32'(RES_F65));
    press(1);
    chk(32'(o_display_digits), 32'(RES_S45));
    press(1);
    chk(32'(o_display_digits), 32'(RES_S55));
    press(1);
    wr(ADDR_FUNC, 32'h1);
    chk(32'(o_display_digits), 32'(RES_S55));
    wr(ADDR_RES_SEL, 32'(RES_F45));
    chk(32'({o_display_digits, o_active_res}), 32'({RES_F45, RES_F65}));
    wr(ADDR_FUNC, 32'h0);
    chk(32'(o_display_digits), 32'(RES_F65));
    wr(ADDR_FUNC, 32'h6);
    rd(ADDR_FUNC, 32'h00000006);
    wr(ADDR_RES_SEL, 32'(RES_F65));
    chk(32'(o_display_digits), 32'(RES_S55));
    wr(ADDR_RES_SEL, 32'(RES_S65));
    chk(32'(o_display_digits), 32'(RES_S65));
    rd(ADDR_RES_SEL, 32'(RES_S65));
    press(2);
    chk(32'(o_display_digits), 32'(RES_S55));
    wr(ADDR_FUNC, 32'h0);
    chk(32'(o_display_digits), 32'(RES_S55));
    $display("test resolution done");
    wr(ADDR_INPUT_R, 32'h01);
    chk(32'(o_high_input_r), 32'h1);
    wr(ADDR_INPUT_R, 32'h21);
    chk(32'(o_high_input_r), 32'h1);
    rd(ADDR_INPUT_R, 32'h00000021);
    wr(ADDR_INPUT_R, 32'h31);
    chk(32'(o_high_input_r), 32'h0);
    wr(ADDR_INPUT_R, 32'h00);
    chk(32'(o_high_input_r), 32'h0);
    wr(ADDR_INPUT_R, 32'h01);
    wr(ADDR_FUNC, 32'h1);
    chk(32'(o_high_input_r), 32'h0);
    $display("test input resistance done");
    report_and_stop;
  end
endmodule
